//--- rtl/sdde_pkg.sv
// Purpose: Constants for the directory-level entry decoder
// Assumes: 64-bit translation entries
// Notes:   Field positions and encodings of both entry formats
package sdde_pkg;
    localparam int ENTRY_W          = 64;
    localparam int HAW_DEFAULT      = 48;
    localparam int BIT_READ         = 0;
    localparam int BIT_WRITE        = 1;
    localparam int BIT_EXEC         = 2;
    localparam int EMT_LO           = 3;
    localparam int EMT_HI           = 5;
    localparam int BIT_IGNORE_ATTR_TABLE_BIT         = 6;
    localparam int BIT_PS           = 7;
    localparam int BIT_ACC          = 8;
    localparam int BIT_DIRTY        = 9;
    localparam int BIT_SNP          = 11;
    localparam int LEAF_ADDR_LO     = 21;
    localparam int TBL_ADDR_LO      = 12;
    localparam int RSV_HI_LO        = 52;
    localparam int BIT_R62          = 62;
    localparam logic [1:0] TTM_LEGACY   = 2'h0;
    localparam logic [2:0] WALK_TYPE_SELECT_SSONLY  = 3'h2;
    localparam logic [2:0] WALK_TYPE_SELECT_NESTED  = 3'h3;
    localparam logic [2:0] EMT_UC       = 3'h0;
    localparam logic [2:0] EMT_WC       = 3'h1;
    localparam logic [2:0] EMT_WT       = 3'h4;
    localparam logic [2:0] EMT_WP       = 3'h5;
    localparam logic [2:0] EMT_WB       = 3'h6;
    typedef enum logic [1:0]
    {
        SDDE_IDLE  = 2'b00,
        SDDE_TABLE = 2'b01,
        SDDE_DONE  = 2'b10
    } sdde_state_t;
endpackage

//--- rtl/sdde_field_split.sv
// Purpose: Split a directory entry into its fields and reserved checks
// Assumes: Entry stable while entry_valid is high
// Notes:   Pure combinational decode
`timescale 1ns/10ps
module sdde_field_split
    import sdde_pkg::*;
#(
    parameter int HOST_ADDR_WIDTH = HAW_DEFAULT
)
(
    input  wire logic [ENTRY_W-1:0] entry,
    input  wire logic               large_page_support_cap,
    input  wire logic               snoop_ctl_cap,
    output logic                    page_size_bit,
    output logic                    rsv_fault,
    output logic [2:0]              perm_rwx
);
    logic rsv_common;
    logic rsv_leaf;
    logic rsv_table;
    logic ps_raw;

    assign ps_raw = entry[BIT_PS];
    // Page-size bit read as zero-required without 2-MByte support
    assign page_size_bit = ps_raw & large_page_support_cap;
    assign rsv_common = entry[BIT_R62] | (|entry[RSV_HI_LO-1:HOST_ADDR_WIDTH])
                        | (ps_raw & ~large_page_support_cap);
    assign rsv_leaf  = (|entry[LEAF_ADDR_LO-1:TBL_ADDR_LO])
                       | (entry[BIT_SNP] & ~snoop_ctl_cap);
    assign rsv_table = entry[BIT_SNP];
    assign rsv_fault = rsv_common | (page_size_bit ? rsv_leaf : rsv_table);
    assign perm_rwx = {entry[BIT_EXEC], entry[BIT_WRITE], entry[BIT_READ]};
endmodule

//--- rtl/sdde_memtype.sv
// Purpose: Resolve extended memory type and attribute-table use
// Assumes: Context fields held steady during a walk
// Notes:   Reserved encodings flag a fault only while the memory type is used
`timescale 1ns/10ps
module sdde_memtype
    import sdde_pkg::*;
(
    input  wire logic [2:0] ext_memtype_field,
    input  wire logic       ignore_attr_table_bit,
    input  wire logic       ext_memtype_enable,
    input  wire logic [1:0] table_mode_select,
    input  wire logic [2:0] walk_type_select,
    input  wire logic       coherent_req,
    output logic            emt_used,
    output logic            emt_bad,
    output logic            pat_use
);
    logic emt_live;
    logic emt_legal;

    function automatic logic emt_ok(input logic [2:0] t);
        return t == EMT_UC || t == EMT_WC || t == EMT_WT ||
               t == EMT_WP || t == EMT_WB;
    endfunction

    assign emt_live  = ext_memtype_enable
                       && table_mode_select != TTM_LEGACY;
    assign emt_used  = emt_live && coherent_req
                       && (walk_type_select == WALK_TYPE_SELECT_SSONLY
                           || walk_type_select == WALK_TYPE_SELECT_NESTED);
    assign emt_legal = emt_ok(ext_memtype_field);
    assign emt_bad   = emt_used && !emt_legal;
    // Attribute table excluded only when ignore bit may act and is set
    assign pat_use   = !(emt_live && coherent_req
                         && walk_type_select == WALK_TYPE_SELECT_NESTED
                         && ignore_attr_table_bit);
endmodule

//--- rtl/sdde_top.sv
// Purpose: Decode directory-level entries of a second-stage walk
// Assumes: One entry presented per entry_valid pulse, table then leaf
// Notes:   Results are registered; walk resets on walk_start
`timescale 1ns/10ps
module sdde_top
    import sdde_pkg::*;
#(
    parameter int HOST_ADDR_WIDTH = HAW_DEFAULT
)
(
    input  wire logic               ref_clk,
    input  wire logic               rst,
    input  wire logic               walk_start,
    input  wire logic               entry_valid,
    input  wire logic [ENTRY_W-1:0] dir_level_entry,
    input  wire logic               access_dirty_track_enable,
    input  wire logic               large_page_support_cap,
    input  wire logic               snoop_ctl_cap,
    input  wire logic               ext_memtype_enable,
    input  wire logic [1:0]         table_mode_select,
    input  wire logic [2:0]         walk_type_select,
    input  wire logic               exec_check_enable,
    input  wire logic               zero_len_read_cap,
    input  wire logic               coherent_req,
    input  wire logic               req_read,
    input  wire logic               req_write,
    input  wire logic               req_exec,
    input  wire logic               req_zero_len,
    output logic                    result_valid,
    output logic                    is_leaf,
    output logic                    trans_fault,
    output logic [HOST_ADDR_WIDTH-1:0]          next_addr,
    output logic                    accessed_flag,
    output logic                    dirty_flag,
    output logic [2:0]              memtype,
    output logic                    memtype_valid,
    output logic                    attr_table_use,
    output logic                    read_ok,
    output logic                    write_ok,
    output logic                    exec_ok,
    output logic                    access_granted
);
    // ************************************************************
    // Field decode
    // ************************************************************
    sdde_state_t    state;
    sdde_state_t    next_state;
    logic           ps_eff;
    logic           rsv_fault;
    logic [2:0]     perm_rwx;
    logic           emt_used;
    logic           emt_bad;
    logic           pat_use;
    logic [2:0]     acc_rwx;
    logic           next_read_ok;
    logic           next_write_ok;
    logic           next_exec_ok;
    logic           next_fault;
    logic [HOST_ADDR_WIDTH-1:0] next_next_addr;
    logic           next_granted;
    logic           read_needed;

    sdde_field_split #(.HOST_ADDR_WIDTH(HOST_ADDR_WIDTH)) u_split
    (
        .entry                  (dir_level_entry),
        .large_page_support_cap (large_page_support_cap),
        .snoop_ctl_cap          (snoop_ctl_cap),
        .page_size_bit          (ps_eff),
        .rsv_fault              (rsv_fault),
        .perm_rwx               (perm_rwx)
    );

    sdde_memtype u_memtype
    (
        .ext_memtype_field     (dir_level_entry[EMT_HI:EMT_LO]),
        .ignore_attr_table_bit (dir_level_entry[BIT_IGNORE_ATTR_TABLE_BIT]),
        .ext_memtype_enable    (ext_memtype_enable),
        .table_mode_select     (table_mode_select),
        .walk_type_select      (walk_type_select),
        .coherent_req          (coherent_req),
        .emt_used              (emt_used),
        .emt_bad               (emt_bad),
        .pat_use               (pat_use)
    );

    // ************************************************************
    // Permission accumulation
    // ************************************************************
    // Walk-start restarts the running AND from all-permitted
    assign acc_rwx = (state == SDDE_TABLE && !walk_start)
                     ? {exec_ok, write_ok, read_ok} : 3'h7;
    assign next_read_ok  = acc_rwx[0] & perm_rwx[0];
    assign next_write_ok = acc_rwx[1] & perm_rwx[1];
    assign next_exec_ok  = acc_rwx[2]
                           & (perm_rwx[2] | ~exec_check_enable);
    // Table address keeps low 12 bits zero: 4-KByte aligned
    assign next_next_addr = ps_eff
        ? {dir_level_entry[HOST_ADDR_WIDTH-1:LEAF_ADDR_LO], {LEAF_ADDR_LO{1'b0}}}
        : {dir_level_entry[HOST_ADDR_WIDTH-1:TBL_ADDR_LO],
           {TBL_ADDR_LO{1'b0}}};
    assign next_fault = rsv_fault | (ps_eff & emt_bad);
    assign read_needed = req_read
        && !(zero_len_read_cap && req_zero_len && next_write_ok);
    assign next_granted = ps_eff && !next_fault
                          && (!read_needed || next_read_ok)
                          && (!req_write || next_write_ok)
                          && (!req_exec || next_exec_ok);

    // ************************************************************
    // Walk state
    // ************************************************************
    always_comb
    begin
        next_state = state;
        case (state)
            SDDE_IDLE, SDDE_DONE, SDDE_TABLE:
            begin
                if (entry_valid)
                begin
                    if (ps_eff || rsv_fault)
                        next_state = SDDE_DONE;
                    else
                        next_state = SDDE_TABLE;
                end
                else if (walk_start)
                    next_state = SDDE_IDLE;
            end
            default:
                next_state = SDDE_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            state <= SDDE_IDLE;
        else
            state <= next_state;
    end

    // ************************************************************
    // Registered results
    // ************************************************************
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            result_valid   <= 1'b0;
            is_leaf        <= 1'b0;
            trans_fault    <= 1'b0;
            next_addr      <= '0;
            accessed_flag  <= 1'b0;
            dirty_flag     <= 1'b0;
            memtype        <= EMT_UC;
            memtype_valid  <= 1'b0;
            attr_table_use <= 1'b1;
            read_ok        <= 1'b0;
            write_ok       <= 1'b0;
            exec_ok        <= 1'b0;
            access_granted <= 1'b0;
        end
        else
        begin
            result_valid <= entry_valid;
            if (entry_valid)
            begin
                is_leaf        <= ps_eff;
                trans_fault    <= next_fault;
                next_addr      <= next_next_addr;
                accessed_flag  <= access_dirty_track_enable
                                  & dir_level_entry[BIT_ACC];
                dirty_flag     <= access_dirty_track_enable & ps_eff
                                  & dir_level_entry[BIT_DIRTY];
                memtype        <= (ps_eff && emt_used)
                                  ? dir_level_entry[EMT_HI:EMT_LO]
                                  : EMT_UC;
                memtype_valid  <= ps_eff & emt_used;
                attr_table_use <= ps_eff ? pat_use : 1'b1;
                read_ok        <= next_read_ok;
                write_ok       <= next_write_ok;
                exec_ok        <= next_exec_ok;
                access_granted <= next_granted;
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    property p_acc_gate;
        @(posedge ref_clk) disable iff (rst)
        entry_valid && !access_dirty_track_enable |=> !accessed_flag;
    endproperty
    a_acc_gate: assert property (p_acc_gate)
        else $error("accessed flag shown with tracking off");

    property p_leaf;
        @(posedge ref_clk) disable iff (rst)
        entry_valid |=> is_leaf == ($past(dir_level_entry[BIT_PS])
                                    && $past(large_page_support_cap));
    endproperty
    a_leaf: assert property (p_leaf)
        else $error("leaf decode wrong");

    property p_ps_rsv;
        @(posedge ref_clk) disable iff (rst)
        entry_valid && dir_level_entry[BIT_PS] && !large_page_support_cap
        |=> trans_fault && !is_leaf;
    endproperty
    a_ps_rsv: assert property (p_ps_rsv)
        else $error("page size not reserved without capability");

    property p_emt_off;
        @(posedge ref_clk) disable iff (rst)
        entry_valid && (!ext_memtype_enable
                        || table_mode_select == TTM_LEGACY)
        |=> !memtype_valid && attr_table_use;
    endproperty
    a_emt_off: assert property (p_emt_off)
        else $error("memory type used while disabled");

    property p_write_deny;
        @(posedge ref_clk) disable iff (rst)
        entry_valid && !dir_level_entry[BIT_WRITE]
        |=> !write_ok ##1 (!write_ok || $past(entry_valid)
                           && ($past(walk_start)
                               || $past(state) != SDDE_TABLE));
    endproperty
    a_write_deny: assert property (p_write_deny)
        else $error("write allowed with write bit clear");

    property p_read_deny;
        @(posedge ref_clk) disable iff (rst)
        entry_valid && !dir_level_entry[BIT_READ] |=> !read_ok;
    endproperty
    a_read_deny: assert property (p_read_deny)
        else $error("read allowed with read bit clear");

    property p_exec;
        @(posedge ref_clk) disable iff (rst)
        entry_valid && exec_check_enable && !dir_level_entry[BIT_EXEC]
        |=> !exec_ok;
    endproperty
    a_exec: assert property (p_exec)
        else $error("execute allowed with execute bit clear");

    property p_align;
        @(posedge ref_clk) disable iff (rst)
        result_valid && !is_leaf
        |-> next_addr == {$past(dir_level_entry[HOST_ADDR_WIDTH-1:TBL_ADDR_LO]),
                          {TBL_ADDR_LO{1'b0}}};
    endproperty
    a_align: assert property (p_align)
        else $error("next table address wrong or not aligned");

    property p_leaf_rsv;
        @(posedge ref_clk) disable iff (rst)
        entry_valid && ps_eff
        && (|dir_level_entry[LEAF_ADDR_LO-1:TBL_ADDR_LO])
        |=> trans_fault;
    endproperty
    a_leaf_rsv: assert property (p_leaf_rsv)
        else $error("leaf reserved bits not faulted");

    property p_dirty;
        @(posedge ref_clk) disable iff (rst)
        entry_valid && !access_dirty_track_enable |=> !dirty_flag;
    endproperty
    a_dirty: assert property (p_dirty)
        else $error("dirty flag shown with tracking off");

    c_leaf:  cover property (@(posedge ref_clk) disable iff (rst)
                             result_valid && is_leaf && access_granted);
    c_walk:  cover property (@(posedge ref_clk) disable iff (rst)
                             state == SDDE_TABLE ##1 result_valid
                             && is_leaf);
    c_fault: cover property (@(posedge ref_clk) disable iff (rst)
                             result_valid && trans_fault);
    c_emt:   cover property (@(posedge ref_clk) disable iff (rst)
                             memtype_valid && !attr_table_use);
endmodule

//--- dv/sdde_table_mem.sv
// Purpose: Table memory model that feeds directory-level entries
// Assumes: Word read combinationally while rd_en is high
// Notes:   Released bus shows the inverse of the last word
`timescale 1ns/10ps
module sdde_table_mem
    import sdde_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               rd_en,
    input  wire logic [3:0]         rd_idx,
    output logic      [ENTRY_W-1:0] rd_data
);
    logic [ENTRY_W-1:0] mem [16];
    logic [ENTRY_W-1:0] last_word = '0;

    // Released bus must never look like a still-valid entry
    assign rd_data = rd_en ? mem[rd_idx] : ~last_word;

    always_ff @(posedge ref_clk)
    begin
        if (rd_en)
            last_word <= mem[rd_idx];
    end

    task automatic put(input int i, input logic [ENTRY_W-1:0] v);
        mem[i] = v;
    endtask
endmodule

//--- dv/tb_sdde_top.sv
// Purpose: Self-checking bench for the directory entry decoder
// Assumes: Inputs change on the falling edge only
// Notes:   Result checked one cycle after each taken entry
`timescale 1ns/10ps
module tb_sdde_top
    import sdde_pkg::*;
();
    localparam logic [63:0] LEAF = 64'h0000_1234_5660_0387;
    localparam logic [63:0] NL   = 64'h0000_00ab_cdef_1100;
    logic        ref_clk, rst, walk_start, entry_valid;
    logic [63:0] dir_level_entry;
    logic        access_dirty_track_enable, large_page_support_cap;
    logic        snoop_ctl_cap, ext_memtype_enable, exec_check_enable;
    logic        zero_len_read_cap, coherent_req, req_read, req_write;
    logic        req_exec, req_zero_len, result_valid, is_leaf;
    logic        trans_fault, accessed_flag, dirty_flag, memtype_valid;
    logic        attr_table_use, read_ok, write_ok, exec_ok;
    logic        access_granted;
    logic [1:0]  table_mode_select;
    logic [2:0]  walk_type_select, memtype;
    logic [47:0] next_addr;
    int          miscompares = 0;
    int          num_checks = 0;

    sdde_table_mem u_sdde_table_mem (.ref_clk, .rd_en(entry_valid),
        .rd_idx(4'h0), .rd_data(dir_level_entry));
    sdde_top #(.HOST_ADDR_WIDTH(48)) u_sdde_top (.ref_clk, .rst, .walk_start,
        .entry_valid, .dir_level_entry, .access_dirty_track_enable,
        .large_page_support_cap, .snoop_ctl_cap, .ext_memtype_enable,
        .table_mode_select, .walk_type_select, .exec_check_enable,
        .zero_len_read_cap, .coherent_req, .req_read, .req_write,
        .req_exec, .req_zero_len, .result_valid, .is_leaf, .trans_fault,
        .next_addr, .accessed_flag, .dirty_flag, .memtype, .memtype_valid,
        .attr_table_use, .read_ok, .write_ok, .exec_ok, .access_granted);

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // ****************
    // Shared tasks
    // ****************
    task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                       input string what);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t %s got %0h", $time, what, got);
        end
    endtask

    task automatic okp(input logic [2:0] e);
        chk({exec_ok, write_ok, read_ok}, e, "perm");
    endtask

    task automatic dflt();
        access_dirty_track_enable = 1'b1;
        large_page_support_cap = 1'b1;
        snoop_ctl_cap = 1'b1;
        ext_memtype_enable = 1'b0;
        table_mode_select = 2'h1;
        walk_type_select = 3'h2;
        exec_check_enable = 1'b1;
        zero_len_read_cap = 1'b0;
        coherent_req = 1'b1;
        {req_read, req_write, req_exec, req_zero_len} = 4'h0;
    endtask

    // Fixed one-cycle answer, valid for exactly one cycle
    task automatic run(input logic [63:0] v);
        u_sdde_table_mem.put(0, v);
        @(negedge ref_clk);
        entry_valid = 1'b1;
        @(negedge ref_clk);
        entry_valid = 1'b0;
        chk(result_valid, 1, "valid");
        @(negedge ref_clk);
        chk(result_valid, 0, "valid pulse");
    endtask

    task automatic wrap_up();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ****************
    // Scenarios
    // ****************
    task automatic t_leaf();
        dflt();
        {req_read, req_write, req_exec} = 3'h7;
        run(LEAF);
        chk(is_leaf, 1, "leaf");
        chk(next_addr, 48'h1234_5660_0000, "leaf addr");
        chk({accessed_flag, dirty_flag}, 2'h3, "a/d on");
        chk(access_granted, 1, "grant");
        access_dirty_track_enable = 1'b0;
        run(LEAF);
        chk({accessed_flag, dirty_flag}, 2'h0, "a/d off");
        $display("t_leaf done");
    endtask

    task automatic t_walk();
        dflt();
        {req_read, req_write, req_exec} = 3'h7;
        for (int k = 0; k < 3; k++)
        begin
            run(NL | (64'h7 ^ (64'h1 << k)));
            chk(is_leaf, 0, "table");
            chk(next_addr, 48'h00ab_cdef_1000, "table addr");
            chk(accessed_flag, 1, "table acc");
            run(LEAF);
            okp(3'h7 ^ (3'h1 << k));
            chk(access_granted, 0, "walk deny");
        end
        run(NL);
        @(negedge ref_clk);
        walk_start = 1'b1;
        @(negedge ref_clk);
        walk_start = 1'b0;
        run(LEAF);
        okp(3'h7);
        $display("t_walk done");
    endtask

    task automatic t_perm();
        dflt();
        {req_read, req_write, req_exec} = 3'h7;
        for (int k = 0; k < 3; k++)
        begin
            run(LEAF ^ (64'h1 << k));
            okp(3'h7 ^ (3'h1 << k));
            chk(access_granted, 0, "leaf deny");
        end
        exec_check_enable = 1'b0;
        run(LEAF ^ 64'h4);
        chk(exec_ok, 1, "exec unchecked");
        $display("t_perm done");
    endtask

    task automatic t_zlr();
        dflt();
        zero_len_read_cap = 1'b1;
        {req_read, req_zero_len} = 2'h3;
        run(LEAF ^ 64'h1);
        chk({read_ok, access_granted}, 2'h1, "zlr skip");
        run(LEAF ^ 64'h3);
        chk({read_ok, access_granted}, 2'h0, "zlr no write");
        zero_len_read_cap = 1'b0;
        run(LEAF ^ 64'h1);
        chk({read_ok, access_granted}, 2'h0, "zlr no cap");
        $display("t_zlr done");
    endtask

    task automatic t_emt();
        bit ok;
        dflt();
        ext_memtype_enable = 1'b1;
        for (int e = 0; e < 8; e++)
        begin
            run(LEAF | (64'(e) << 3));
            ok = e inside {0, 1, 4, 5, 6};
            chk(trans_fault, !ok, "emt code");
            if (ok)
                chk({memtype_valid, memtype}, {1'b1, 3'(e)}, "emt");
        end
        // Case 4 is nested with all enables on
        for (int c = 0; c < 5; c++)
        begin
            dflt();
            ext_memtype_enable = (c != 0);
            table_mode_select = (c == 1) ? 2'h0 : 2'h1;
            walk_type_select = (c == 2) ? 3'h1 : (c == 4) ? 3'h3 : 3'h2;
            coherent_req = (c != 3);
            run(LEAF | 64'h30);
            chk(memtype_valid, c == 4, "emt use");
            run(LEAF | 64'h38);
            chk(trans_fault, c == 4, "emt rsv");
        end
        $display("t_emt done");
    endtask

    task automatic t_ignore_attr_table_bit();
        for (int c = 0; c < 6; c++)
        begin
            dflt();
            ext_memtype_enable = (c != 3);
            walk_type_select = (c == 1) ? 3'h2 : 3'h3;
            coherent_req = (c != 2);
            table_mode_select = (c == 4) ? 2'h0 : 2'h1;
            run(LEAF | ((c == 5) ? 64'h0 : 64'h40));
            chk(attr_table_use, c != 0, "attr table");
        end
        $display("t_ignore_attr_table_bit done");
    endtask

    task automatic t_rsv();
        logic [63:0] v [6];
        bit          f [6];
        dflt();
        v = '{LEAF | 64'h4000_0000_0000_0000, LEAF | 64'h1000,
              NL | 64'h800, LEAF | 64'h0004_0000_0000_0000,
              LEAF | 64'hbff0_0000_0000_0400, NL | 64'h678};
        f = '{1, 1, 1, 1, 0, 0};
        for (int i = 0; i < 6; i++)
        begin
            run(v[i]);
            chk(trans_fault, f[i], "reserved");
        end
        snoop_ctl_cap = 1'b0;
        run(LEAF | 64'h800);
        chk(trans_fault, 1, "snoop no cap");
        large_page_support_cap = 1'b0;
        run(LEAF);
        chk(trans_fault, 1, "ps no cap");
        $display("t_rsv done");
    endtask

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        $display("[FAIL] %0t timeout", $time);
        wrap_up();
    end

    initial
    begin
        dflt();
        rst = 1'b1;
        walk_start = 1'b0;
        entry_valid = 1'b0;
        repeat (16) @(negedge ref_clk);
        chk({result_valid, attr_table_use}, 2'h1, "reset");
        rst = 1'b0;
        t_leaf();
        t_walk();
        t_perm();
        t_zlr();
        t_emt();
        t_ignore_attr_table_bit();
        t_rsv();
        wrap_up();
    end
endmodule
